// ---- mdi_cfg.svh ----
// Purpose: Offsets, fields, reset values and timing counts of the driver input block.
// Assumes: AHB-Lite word registers decoded on the low eight address bits.
// Notes: Signal assignment bits share one numbering in every preset mask.
`ifndef MDI_CFG_SVH
`define MDI_CFG_SVH
`define MDI_OFS_CTRL 8'h00
`define MDI_OFS_CMD 8'h04
`define MDI_OFS_STATUS 8'h08
`define MDI_OFS_ENC 8'h0c
`define MDI_OFS_POSERR 8'h10
`define MDI_OFS_HIST 8'h14
`define MDI_OFS_IOASSIGN 8'h18
`define MDI_CTRL_ALARM_EN 0
`define MDI_CTRL_END_SRC 1
`define MDI_CTRL_TIM_SEL 2
`define MDI_CTRL_ENC_SEL 3
`define MDI_CTRL_READY_EN 4
`define MDI_CTRL_HOME_DCL 5
`define MDI_CTRL_PRESET_LO 8
`define MDI_CTRL_RST 10'h004
`define MDI_CMD_APPLY 0
`define MDI_CMD_CLR_CONN 1
`define MDI_CMD_CLR_ENC 2
`define MDI_CODE_DRV_ALARM 8'h6e
`define MDI_CODE_CONN_ERR 8'h6f
`define MDI_READY_TIMEOUT_S 3
`define MDI_CLK_HZ 50000000
`define MDI_IO_DEFAULT 18'h3f000
`define MDI_PUSH_ASG 18'h00007
`define MDI_PUSH_DEL 18'h20000
`define MDI_EXPAND_ASG 18'h001fb
`define MDI_EXPAND_DEL 18'h32000
`define MDI_SLESS_ASG 18'h00ff0
`define MDI_SLESS_DEL 18'h0d008
`define MDI_POSRD_ASG 18'h009f8
`define MDI_POSRD_DEL 18'h09000
`endif

// ---- mdi_pkg.sv ----
// Purpose: Types shared by the driver input block.
// Assumes: Nothing beyond the configuration header.
// Notes: Input struct fields are true when the input element conducts.
package mdi_pkg;
    typedef struct packed {
        logic alarm;
        logic endIn;
        logic timingSingleEndedIn;
        logic timingDifferentialIn;
        logic extEncZ;
        logic feedbackPhaseA;
        logic feedbackPhaseB;
        logic extEncA;
        logic extEncB;
        logic ready;
        logic homeSensor;
    } mdi_drv_in_t;
    typedef enum logic [1:0] {
        MDI_IDLE = 2'b00,
        MDI_UNASSIGN = 2'b01,
        MDI_ASSIGN = 2'b11
    } mdi_preset_state_t;
    typedef enum logic [1:0] {
        MDI_PUSH = 2'b00,
        MDI_EXPAND = 2'b01,
        MDI_SENSORLESS = 2'b10,
        MDI_POS_READ = 2'b11
    } mdi_preset_t;
endpackage

// ---- mdi_input.sv ----
// Purpose: Driver input conditioning, end and timing selection, encoder and I/O presets.
// Assumes: AHB-Lite slave with zero wait states; single clock; inputs synchronous.
// Notes: The ready timeout is a parameter so a simulation can shorten it.
//
// Notes on behaviour
// RL1: Enabled driver alarm raises code 6Eh, decelerates to stop, halts sequence.
// RL2: Active driver alarm blocks pulse output; other commands still run.
// RL3: Alarm input is normally closed: OFF means alarm, ON means healthy.
// RL4: Alarm enable gates alarm use; reset disabled, one enables.
// RL5: Alarm clears itself when input conducts; each occurrence is logged.
// RL6: End source zero selects internal end, one selects driver end.
// RL7: Selected end feeds the end wait, end output and home checks.
// RL8: Timing pulse with home sensor locates home accurately.
// RL9: Encoder and timing selects choose single, differential or external Z.
// RL10: Timing select zero routes the differential timing input.
// RL11: Count A/B pulses; position error is commanded minus feedback.
// RL12: Position error is offered to end check, sequences and miss-step logic.
// RL13: Encoder select zero counts driver feedback, one counts external encoder.
// RL14: Input is ON when its isolated element conducts, not by voltage.
// RL15: Preset first unassigns unneeded signals, then assigns required ones.
// RL16: Push preset assigns three data selects, removes brake release.
// RL17: Expansion preset sets home deviation clear; home then clears deviation.
// RL18: Sensorless preset assigns position read and home signals, removes others.
// RL19: Every driver input passes two flip-flops before use.
// RL20: Start without ready holds pulses; after three seconds raise 6Fh.
`timescale 1ns/1ps
`include "mdi_cfg.svh"
module mdi_input #(
    parameter int unsigned READY_TIMEOUT_CYC = `MDI_READY_TIMEOUT_S * `MDI_CLK_HZ
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire mdi_pkg::mdi_drv_in_t drvIn,
    input wire logic internalEnd,
    input wire logic homeSeekActive,
    input wire logic startReq,
    input wire logic [31:0] commandedPosition,
    output logic pulseEnable,
    output logic decelStop,
    output logic sequenceHalt,
    output logic systemAlarm,
    output logic [7:0] alarmCode,
    output logic motionEnd,
    output logic homeFound,
    output logic deviationClear,
    output logic [31:0] positionError
);
    import mdi_pkg::*;

    logic [10:0] syncA_reg;
    logic [10:0] syncB_reg;
    mdi_drv_in_t drv;
    logic [9:0] ctrl_reg;
    logic wrPend_reg;
    logic [7:0] wrAddr_reg;
    logic [31:0] readMux;
    logic cmdWr;
    logic drvAlarm_reg;
    logic alarmCond;
    logic alarmEdge;
    logic connErr_reg;
    logic connErrEvt;
    logic readyWait_reg;
    logic readyWait_next;
    logic [31:0] waitCnt_reg;
    logic [15:0] histCount_reg;
    logic [7:0] histCode_reg;
    logic [1:0] encPrev_reg;
    logic [1:0] encCur;
    logic [31:0] encoderCount_reg;
    logic timingSel;
    logic timingPrev_reg;
    logic timingRise;
    logic [17:0] ioAssign_reg;
    logic [17:0] asgMask;
    logic [17:0] delMask;
    mdi_preset_state_t preset_reg;

    // Two stages keep metastability out of every decision below.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA_reg <= 11'h000;
            syncB_reg <= 11'h000;
        end else begin
            syncA_reg <= drvIn; // RL19
            syncB_reg <= syncA_reg; // RL19
        end
    end
    assign drv = mdi_drv_in_t'(syncB_reg);

    // Bus slave: every access completes without wait states and answers OKAY.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend_reg <= 1'b0;
            wrAddr_reg <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wrPend_reg <= hsel && htrans[1] && hready && hwrite;
            wrAddr_reg <= haddr[7:0];
            if (hsel && htrans[1] && hready && !hwrite) begin
                hrdata <= readMux;
            end
        end
    end

    always_comb begin
        readMux = 32'h0000_0000;
        unique case (haddr[7:0])
            `MDI_OFS_CTRL: readMux = {22'h000000, ctrl_reg};
            `MDI_OFS_STATUS: readMux = {16'h0000, alarmCode, 1'b0,
                preset_reg != MDI_IDLE, pulseEnable, readyWait_reg,
                timingPrev_reg, motionEnd, connErr_reg, drvAlarm_reg};
            `MDI_OFS_ENC: readMux = encoderCount_reg;
            `MDI_OFS_POSERR: readMux = positionError; // RL12
            `MDI_OFS_HIST: readMux = {8'h00, histCode_reg, histCount_reg};
            `MDI_OFS_IOASSIGN: readMux = {14'h0000, ioAssign_reg};
            default: readMux = 32'h0000_0000;
        endcase
    end
    assign cmdWr = wrPend_reg && (wrAddr_reg == `MDI_OFS_CMD);

    // Control word; the expansion preset also turns on home deviation clear.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg <= `MDI_CTRL_RST; // RL4 RL6 RL9
        end else if (wrPend_reg && wrAddr_reg == `MDI_OFS_CTRL) begin
            ctrl_reg <= {hwdata[9:8], 2'b00, hwdata[5:0]};
        end else if (preset_reg == MDI_ASSIGN && ctrl_reg[9:8] == MDI_EXPAND) begin
            ctrl_reg[`MDI_CTRL_HOME_DCL] <= 1'b1; // RL17
        end
    end

    // Alarm input is normally closed, so a dark input element means alarm.
    assign alarmCond = ctrl_reg[`MDI_CTRL_ALARM_EN] && !drv.alarm; // RL3 RL4 RL14
    assign alarmEdge = alarmCond && !drvAlarm_reg;
    assign connErrEvt = readyWait_reg && !drv.ready &&
        (waitCnt_reg == READY_TIMEOUT_CYC - 1);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drvAlarm_reg <= 1'b0;
        end else begin
            drvAlarm_reg <= alarmCond; // RL5
        end
    end

    // Ready wait; it ends when ready conducts, when the timeout fires or when the ready enable bit is cleared.
    always_comb begin
        readyWait_next = readyWait_reg;
        if (startReq && ctrl_reg[`MDI_CTRL_READY_EN] && !drv.ready) begin
            readyWait_next = 1'b1; // RL20
        end
        if (drv.ready || connErrEvt || !ctrl_reg[`MDI_CTRL_READY_EN]) begin
            readyWait_next = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readyWait_reg <= 1'b0;
            waitCnt_reg <= 32'h0000_0000;
        end else begin
            readyWait_reg <= readyWait_next;
            if (readyWait_reg && readyWait_next) begin
                waitCnt_reg <= waitCnt_reg + 32'h0000_0001; // RL20
            end else begin
                waitCnt_reg <= 32'h0000_0000;
            end
        end
    end

    // A new timeout in the clearing cycle keeps the error set.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            connErr_reg <= 1'b0;
        end else if (connErrEvt) begin
            connErr_reg <= 1'b1; // RL20
        end else if (cmdWr && hwdata[`MDI_CMD_CLR_CONN]) begin
            connErr_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pulseEnable <= 1'b1;
            decelStop <= 1'b0;
            sequenceHalt <= 1'b0;
            systemAlarm <= 1'b0;
            alarmCode <= 8'h00;
        end else begin
            pulseEnable <= !alarmCond && !readyWait_next && !connErrEvt; // RL2 RL20
            decelStop <= alarmEdge || connErrEvt; // RL1
            sequenceHalt <= alarmEdge || connErrEvt; // RL1
            systemAlarm <= alarmCond || connErrEvt || connErr_reg; // RL1
            if (alarmEdge) begin
                alarmCode <= `MDI_CODE_DRV_ALARM; // RL1
            end else if (connErrEvt) begin
                alarmCode <= `MDI_CODE_CONN_ERR; // RL20
            end else if (!alarmCond && !connErr_reg) begin
                alarmCode <= 8'h00;
            end
        end
    end

    // History keeps every occurrence, even those that clear on their own; an alarm and a timeout in one cycle log once as 6Eh.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            histCount_reg <= 16'h0000;
            histCode_reg <= 8'h00;
        end else if (alarmEdge || connErrEvt) begin
            histCount_reg <= histCount_reg + 16'h0001; // RL5
            histCode_reg <= alarmEdge ? `MDI_CODE_DRV_ALARM : `MDI_CODE_CONN_ERR; // RL5
        end
    end

    // Quadrature counter; a double step between samples cannot be resolved and is dropped.
    assign encCur = ctrl_reg[`MDI_CTRL_ENC_SEL] ? {drv.extEncA, drv.extEncB} :
        {drv.feedbackPhaseA, drv.feedbackPhaseB}; // RL13
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            encPrev_reg <= 2'b00;
            encoderCount_reg <= 32'h0000_0000;
        end else begin
            encPrev_reg <= encCur;
            if (cmdWr && hwdata[`MDI_CMD_CLR_ENC]) begin
                encoderCount_reg <= 32'h0000_0000;
            end else if ((encCur[1] ^ encPrev_reg[1]) ^ (encCur[0] ^ encPrev_reg[0])) begin
                if (encCur[1] ^ encPrev_reg[0]) begin
                    encoderCount_reg <= encoderCount_reg + 32'h0000_0001; // RL11
                end else begin
                    encoderCount_reg <= encoderCount_reg - 32'h0000_0001; // RL11
                end
            end
        end
    end

    // Feedback position equals the encoder count; the error feeds several consumers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            positionError <= 32'h0000_0000;
        end else begin
            positionError <= commandedPosition - encoderCount_reg; // RL11 RL12
        end
    end

    // End source and timing source selection.
    assign timingSel = ctrl_reg[`MDI_CTRL_ENC_SEL] ? drv.extEncZ :
        (ctrl_reg[`MDI_CTRL_TIM_SEL] ? drv.timingSingleEndedIn :
        drv.timingDifferentialIn); // RL9 RL10
    assign timingRise = timingSel && !timingPrev_reg;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            timingPrev_reg <= 1'b0;
            motionEnd <= 1'b0;
            homeFound <= 1'b0;
            deviationClear <= 1'b0;
        end else begin
            timingPrev_reg <= timingSel;
            motionEnd <= ctrl_reg[`MDI_CTRL_END_SRC] ? drv.endIn : internalEnd; // RL6 RL7
            homeFound <= homeSeekActive && drv.homeSensor && timingRise; // RL8
            deviationClear <= homeSeekActive && drv.homeSensor && timingRise &&
                ctrl_reg[`MDI_CTRL_HOME_DCL]; // RL17
        end
    end

    // Preset masks per selected driver function.
    always_comb begin
        asgMask = `MDI_PUSH_ASG;
        delMask = `MDI_PUSH_DEL;
        unique case (mdi_preset_t'(ctrl_reg[9:8]))
            MDI_PUSH: begin
                asgMask = `MDI_PUSH_ASG; // RL16
                delMask = `MDI_PUSH_DEL; // RL16
            end
            MDI_EXPAND: begin
                asgMask = `MDI_EXPAND_ASG;
                delMask = `MDI_EXPAND_DEL;
            end
            MDI_SENSORLESS: begin
                asgMask = `MDI_SLESS_ASG; // RL18
                delMask = `MDI_SLESS_DEL; // RL18
            end
            MDI_POS_READ: begin
                asgMask = `MDI_POSRD_ASG;
                delMask = `MDI_POSRD_DEL;
            end
        endcase
    end

    // Removal happens a cycle ahead of assignment so no pin is ever doubly claimed.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            preset_reg <= MDI_IDLE;
            ioAssign_reg <= `MDI_IO_DEFAULT;
        end else begin
            unique case (preset_reg)
                MDI_IDLE: begin
                    if (cmdWr && hwdata[`MDI_CMD_APPLY]) begin
                        preset_reg <= MDI_UNASSIGN;
                    end
                end
                MDI_UNASSIGN: begin
                    ioAssign_reg <= ioAssign_reg & ~delMask; // RL15
                    preset_reg <= MDI_ASSIGN;
                end
                MDI_ASSIGN: begin
                    ioAssign_reg <= ioAssign_reg | asgMask; // RL15
                    preset_reg <= MDI_IDLE;
                end
                default: preset_reg <= MDI_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_alarm_stop;
        $rose(drvAlarm_reg) |-> decelStop && sequenceHalt && alarmCode == 8'h6e;
    endproperty
    a_alarm_stop: assert property (p_alarm_stop) else $error("alarm stop missing"); // RL1
    property p_no_pulse;
        drvAlarm_reg |-> !pulseEnable;
    endproperty
    a_no_pulse: assert property (p_no_pulse) else $error("pulses during alarm"); // RL2
    property p_nc_logic;
        ctrl_reg[0] && !drv.alarm |=> drvAlarm_reg;
    endproperty
    a_nc_logic: assert property (p_nc_logic) else $error("open input not alarm"); // RL3
    property p_alarm_gate;
        !ctrl_reg[0] |=> !drvAlarm_reg;
    endproperty
    a_alarm_gate: assert property (p_alarm_gate) else $error("alarm while disabled"); // RL4
    property p_hist;
        $rose(drvAlarm_reg) |-> histCount_reg == $past(histCount_reg) + 16'h0001;
    endproperty
    a_hist: assert property (p_hist) else $error("alarm not logged"); // RL5
    property p_end_src;
        ##1 motionEnd == $past(ctrl_reg[1] ? drv.endIn : internalEnd);
    endproperty
    a_end_src: assert property (p_end_src) else $error("wrong end source"); // RL6
    property p_pos_err;
        ##1 positionError == $past(commandedPosition - encoderCount_reg);
    endproperty
    a_pos_err: assert property (p_pos_err) else $error("position error wrong"); // RL11
    property p_preset_seq;
        preset_reg == MDI_UNASSIGN |=> preset_reg == MDI_ASSIGN ##1 preset_reg == MDI_IDLE;
    endproperty
    a_preset_seq: assert property (p_preset_seq) else $error("preset order wrong"); // RL15
    property p_dev_clr;
        deviationClear |-> homeFound && $past(ctrl_reg[5]);
    endproperty
    a_dev_clr: assert property (p_dev_clr) else $error("clear without home"); // RL17
    property p_conn_err;
        connErrEvt |=> connErr_reg && alarmCode != 8'h00 && !pulseEnable;
    endproperty
    a_conn_err: assert property (p_conn_err) else $error("timeout not raised"); // RL20

    c_alarm: cover property ($rose(drvAlarm_reg));
    c_home: cover property (deviationClear);
    c_timeout: cover property (connErrEvt);
    c_preset: cover property (preset_reg == MDI_ASSIGN);
endmodule

// ---- mdi_driver_model.sv ----
// Purpose: Behavioural stepping driver that feeds the driver input block.
// Assumes: Bench commands steps one at a time, spaced at least two cycles.
// Notes: External encoder lines toggle every cycle so a wrong source shows at once.
`timescale 1ns/1ps
module mdi_driver_model (
    input wire logic clk,
    input wire logic alarmActive,
    input wire logic readyOn,
    input wire logic endOn,
    input wire logic homeOn,
    input wire logic timSeOn,
    input wire logic timDiffOn,
    input wire logic stepUp,
    input wire logic stepDown,
    output mdi_pkg::mdi_drv_in_t drvIn
);
    import mdi_pkg::*;
    logic [1:0] phaseReg = 2'h0;
    logic extReg = 1'b0;
    always_ff @(posedge clk) begin
        if (stepUp) begin
            phaseReg <= phaseReg + 2'h1;
        end else if (stepDown) begin
            phaseReg <= phaseReg - 2'h1;
        end
    end
    always_ff @(posedge clk) begin
        extReg <= ~extReg;
    end
    // Alarm element stops conducting while the driver is in alarm.
    // One assignment packs the fields MSB first; phase A leads phase B when counting up.
    assign drvIn = {
        ~alarmActive,
        endOn,
        timSeOn,
        timDiffOn,
        extReg,
        phaseReg[1] ^ phaseReg[0],
        phaseReg[1],
        extReg,
        ~extReg,
        readyOn,
        homeOn
    };
endmodule

// ---- mdi_input_test.sv ----
// Purpose: Self-checking bench for the driver input block.
// Assumes: Zero wait state slave; ready timeout shortened to 20 cycles.
// Notes: Each bus task leaves one idle cycle so reads never see stale data.
`timescale 1ns/1ps
`include "mdi_cfg.svh"
module mdi_input_test;
    import mdi_pkg::*;
    localparam int TMO = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hreadyout, hresp, pulseEnable, decelStop, sequenceHalt, systemAlarm;
    logic motionEnd, homeFound, deviationClear;
    logic [31:0] hrdata, positionError;
    logic [7:0] alarmCode;
    mdi_drv_in_t drvIn;
    logic internalEnd = 1'b0;
    logic homeSeekActive = 1'b0;
    logic startReq = 1'b0;
    logic [31:0] commandedPosition = 32'h0;
    logic alarmActive = 1'b0;
    logic readyOn = 1'b1;
    logic endOn = 1'b0;
    logic homeOn = 1'b0;
    logic timSeOn = 1'b0;
    logic timDiffOn = 1'b0;
    logic stepUp = 1'b0;
    logic stepDown = 1'b0;
    int n_fail = 0;
    int checked = 0;
    int seed = 20;
    int nDecel = 0;
    int nHalt = 0;
    int nHome = 0;
    int nDcl = 0;
    logic [31:0] rdv;
    logic [17:0] assignExp;
    int cnt;
    logic [17:0] asgTab [4] = '{`MDI_PUSH_ASG, `MDI_EXPAND_ASG, `MDI_SLESS_ASG, `MDI_POSRD_ASG};
    logic [17:0] delTab [4] = '{`MDI_PUSH_DEL, `MDI_EXPAND_DEL, `MDI_SLESS_DEL, `MDI_POSRD_DEL};
    always #10 clk = ~clk;
    mdi_input #(.READY_TIMEOUT_CYC(TMO)) mdi_input_i (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .drvIn(drvIn), .internalEnd(internalEnd), .homeSeekActive(homeSeekActive),
        .startReq(startReq), .commandedPosition(commandedPosition),
        .pulseEnable(pulseEnable), .decelStop(decelStop), .sequenceHalt(sequenceHalt),
        .systemAlarm(systemAlarm), .alarmCode(alarmCode), .motionEnd(motionEnd),
        .homeFound(homeFound), .deviationClear(deviationClear),
        .positionError(positionError));
    mdi_driver_model mdi_driver_model_i (.clk(clk), .alarmActive(alarmActive),
        .readyOn(readyOn), .endOn(endOn), .homeOn(homeOn), .timSeOn(timSeOn),
        .timDiffOn(timDiffOn), .stepUp(stepUp), .stepDown(stepDown), .drvIn(drvIn));
    always @(posedge clk) begin
        nDecel <= nDecel + (decelStop === 1'b1);
        nHalt <= nHalt + (sequenceHalt === 1'b1);
        nHome <= nHome + (homeFound === 1'b1);
        nDcl <= nDcl + (deviationClear === 1'b1);
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, seen);
            n_fail++;
        end
    endtask
    task automatic busOp(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
        chk("hresp", {31'h0, hresp}, 32'h0);
    endtask
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        busOp(1'b0, a, 32'h0);
        chk(what, rdv, exp);
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #(20 * 20000);
        n_fail++;
        finish_test();
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd("ctrl", `MDI_OFS_CTRL, 32'h4);
        rd("assign", `MDI_OFS_IOASSIGN, 32'h3f000);
        rd("unmapped", 8'h40, 32'h0);
        $display("test reset done");
        busOp(1'b1, `MDI_OFS_CTRL, 32'h5);
        alarmActive <= 1'b1;
        settle(6);
        chk("alarm", {systemAlarm, alarmCode, pulseEnable}, {1'b1, 8'h6e, 1'b0});
        chk("decel", nDecel * 2 + nHalt, 3);
        rd("ctrl", `MDI_OFS_CTRL, 32'h5);
        alarmActive <= 1'b0;
        settle(6);
        chk("alarm off", {systemAlarm, pulseEnable}, 2'b01);
        rd("hist", `MDI_OFS_HIST, 32'h006e0001);
        busOp(1'b1, `MDI_OFS_CTRL, 32'h4);
        alarmActive <= 1'b1;
        settle(6);
        chk("alarm masked", {systemAlarm, pulseEnable}, 2'b01);
        alarmActive <= 1'b0;
        $display("test alarm done");
        for (int src = 0; src < 2; src++) begin
            busOp(1'b1, `MDI_OFS_CTRL, 32'h4 | (src << 1));
            repeat (4) begin
                internalEnd <= $random(seed);
                endOn <= $random(seed);
                settle(5);
                chk("end", motionEnd, src ? endOn : internalEnd);
            end
        end
        $display("test end done");
        busOp(1'b1, `MDI_OFS_CTRL, 32'h4);
        busOp(1'b1, `MDI_OFS_CMD, 32'h4);
        cnt = 0;
        repeat (24) begin
            if ($random(seed) & 1) begin
                stepUp <= 1'b1;
                cnt++;
            end else begin
                stepDown <= 1'b1;
                cnt--;
            end
            @(posedge clk);
            stepUp <= 1'b0;
            stepDown <= 1'b0;
            settle(2);
        end
        commandedPosition <= $random(seed);
        settle(5);
        rd("enc", `MDI_OFS_ENC, cnt);
        chk("poserr", positionError, commandedPosition - cnt);
        rd("poserr reg", `MDI_OFS_POSERR, commandedPosition - cnt);
        $display("test encoder done");
        assignExp = 18'h3f000;
        for (int p = 0; p < 4; p++) begin
            busOp(1'b1, `MDI_OFS_CTRL, 32'h4 | (p << 8));
            busOp(1'b1, `MDI_OFS_CMD, 32'h1);
            settle(4);
            assignExp = (assignExp & ~delTab[p]) | asgTab[p];
            rd("assign", `MDI_OFS_IOASSIGN, {14'h0, assignExp});
            rd("ctrl", `MDI_OFS_CTRL, 32'h4 | (p << 8) | (p == 1 ? 32'h20 : 32'h0));
        end
        $display("test preset done");
        busOp(1'b1, `MDI_OFS_CTRL, 32'h14);
        readyOn <= 1'b0;
        settle(4);
        startReq <= 1'b1;
        @(posedge clk);
        startReq <= 1'b0;
        settle(3);
        chk("ready hold", pulseEnable, 1'b0);
        settle(TMO + 6);
        chk("conn", {systemAlarm, alarmCode}, {1'b1, 8'h6f});
        readyOn <= 1'b1;
        busOp(1'b1, `MDI_OFS_CMD, 32'h2);
        settle(4);
        chk("conn clear", {systemAlarm, pulseEnable}, 2'b01);
        readyOn <= 1'b0;
        settle(4);
        startReq <= 1'b1;
        @(posedge clk);
        startReq <= 1'b0;
        settle(3);
        chk("ready hold 2", pulseEnable, 1'b0);
        readyOn <= 1'b1;
        settle(5);
        chk("ready release", {systemAlarm, pulseEnable}, 2'b01);
        $display("test ready done");
        homeSeekActive <= 1'b1;
        homeOn <= 1'b1;
        for (int sel = 0; sel < 2; sel++) begin
            busOp(1'b1, `MDI_OFS_CTRL, 32'h20 | (sel << 2));
            settle(4);
            cnt = nHome;
            repeat (2) begin
                timSeOn <= 1'b1;
                settle(4);
                timSeOn <= 1'b0;
                settle(4);
            end
            repeat (3) begin
                timDiffOn <= 1'b1;
                settle(4);
                timDiffOn <= 1'b0;
                settle(4);
            end
            settle(2);
            chk("home", nHome - cnt, sel ? 2 : 3);
            chk("devclr", nDcl, nHome);
        end
        $display("test home done");
        busOp(1'b1, `MDI_OFS_CTRL, 32'h2c);
        busOp(1'b1, `MDI_OFS_CMD, 32'h4);
        settle(4);
        cnt = nHome;
        repeat (2) begin
            stepUp <= 1'b1;
            @(posedge clk);
            stepUp <= 1'b0;
            settle(2);
        end
        settle(14);
        chk("ext z", nHome - cnt, 10);
        rd("ext enc", `MDI_OFS_ENC, 32'h0);
        $display("test external done");
        finish_test();
    end
endmodule
